/* File: rtl/spcr_pkg.sv */
package spcr_pkg;

    localparam int ADR_W = 11;
    localparam int DAT_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_ENABLE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
    localparam logic [7:0] IDX_LINE_DRV = 8'hf0;
    localparam logic [7:0] IDX_IR_CTRL = 8'hf1;

    // Address bit that selects the second port
    localparam int PORT_SEL_BIT = 10;

    // Field positions
    localparam int ENABLE_BIT = 0;
    localparam int RTS_INV_BIT = 5;
    localparam int DIFF_MODE_BIT = 4;
    localparam int RX_DLY_BIT = 3;
    localparam int TX_DLY_BIT = 2;
    localparam int IR_MODE_LSB = 3;
    localparam int HALF_DUPLEX_BIT = 2;
    localparam int IR_TX_INV_BIT = 1;
    localparam int IR_RX_INV_BIT = 0;

    // Reset values
    localparam logic P1_ENABLE_RST = 1'b1;
    localparam logic P2_ENABLE_RST = 1'b1;
    localparam logic [7:0] P1_BASE_HI_RST = 8'h03;
    localparam logic [7:0] P1_BASE_LO_RST = 8'hf8;
    localparam logic [7:0] P2_BASE_HI_RST = 8'h02;
    localparam logic [7:0] P2_BASE_LO_RST = 8'hf8;
    localparam logic [3:0] P1_IRQ_RST = 4'h4;
    localparam logic [3:0] P2_IRQ_RST = 4'h3;
    localparam logic [1:0] IR_MODE_RST = 2'h0;
    localparam logic HALF_DUPLEX_RST = 1'b1;

    // Infrared mode codes
    localparam logic [1:0] IR_MODE_FIXED = 2'h2;
    localparam logic [1:0] IR_MODE_RATIO = 2'h3;

    // Timing
    localparam int CLK_NS = 50;
    localparam int IR_PULSE_NS = 1600;
    localparam int IR_PULSE_CYC_I = (IR_PULSE_NS / CLK_NS) < 1 ? 1 : IR_PULSE_NS / CLK_NS;
    localparam logic [5:0] IR_PULSE_CYC = 6'(IR_PULSE_CYC_I);
    localparam logic [5:0] IR_PULSE_TICKS = 6'h03;
    localparam int TICKS_PER_BIT = 16;
    localparam int CHAR_BITS = 10;
    localparam int TURN_CHARS = 4;
    localparam logic [9:0] TURN_TICKS = 10'(TURN_CHARS * CHAR_BITS * TICKS_PER_BIT);
    localparam logic [3:0] LAST_PHASE = 4'(TICKS_PER_BIT - 1);

    typedef struct packed {
        logic en;
        logic [7:0] base_hi;
        logic [7:0] base_lo;
        logic [3:0] irq;
        logic rts_inv;
        logic diff_mode;
        logic rx_dly;
        logic tx_dly;
    } spcr_port_s;

    typedef struct packed {
        logic [1:0] mode;
        logic half;
        logic tx_inv;
        logic rx_inv;
    } spcr_ir_s;

    typedef enum logic [1:0] {
        DIR_RX,
        DIR_RX_WAIT,
        DIR_TX_WAIT,
        DIR_TX
    } spcr_dir_e;

    typedef struct packed {
        spcr_port_s [1:0] port;
        spcr_ir_s ir;
        logic ack;
        logic [7:0] rdata;
        logic [1:0] rts_n;
        logic [2:0] rx_sync;
        logic rx_level;
        logic rxd;
        spcr_dir_e dir;
        logic [9:0] dly_cnt;
        logic [3:0] phase;
        logic txd_d;
        logic [5:0] pulse_cnt;
        logic pulse_ticks;
        logic ir_tx;
    } spcr_state_s;

endpackage

/* File: rtl/spcr_top.sv */
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module spcr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [spcr_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [spcr_pkg::DAT_W-1:0] dat_i,
    output logic [spcr_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    output logic [1:0] enable_o,
    output logic [1:0][15:0] io_base_o,
    output logic [1:0][3:0] irq_channel_o,
    input wire logic [1:0] tx_active_i,
    input wire logic [1:0] uart_rts_n_i,
    output logic [1:0] rts_n_o,
    input wire logic baud16_tick_i,
    input wire logic txd_i,
    input wire logic tx_pending_i,
    output logic tx_hold_o,
    input wire logic ir_receive_input_i,
    output logic ir_transmit_output_o,
    output logic rxd_o
);

    spcr_pkg::spcr_state_s st_r;
    spcr_pkg::spcr_state_s st_nxt;

    logic [7:0] idx;
    logic p2;
    logic wr_now;
    logic ir_on;
    logic rx_open;

    assign idx = adr_i[9:2];
    assign p2 = adr_i[spcr_pkg::PORT_SEL_BIT];
    // Writes land at the edge on which the master samples ack
    assign wr_now = cyc_i && stb_i && we_i && st_r.ack && sel_i[0];
    assign ir_on = st_r.ir.mode[1];
    assign rx_open = !st_r.ir.half || (st_r.dir == spcr_pkg::DIR_RX);

    // Read decode; reserved bits and unmapped indices give zero
    function automatic logic [7:0] read_reg(input spcr_pkg::spcr_port_s pc, input spcr_pkg::spcr_ir_s irc,
                                            input logic second, input logic [7:0] ix);
        logic [7:0] d;
        d = 8'h00;
        unique case (ix)
            spcr_pkg::IDX_ENABLE: d[spcr_pkg::ENABLE_BIT] = pc.en;
            spcr_pkg::IDX_BASE_HI: d = pc.base_hi;
            spcr_pkg::IDX_BASE_LO: d = pc.base_lo;
            spcr_pkg::IDX_IRQ_SEL: d[3:0] = pc.irq;
            spcr_pkg::IDX_LINE_DRV:
            begin
                d[spcr_pkg::RTS_INV_BIT] = pc.rts_inv;
                d[spcr_pkg::DIFF_MODE_BIT] = pc.diff_mode;
                d[spcr_pkg::RX_DLY_BIT] = second & pc.rx_dly;
                d[spcr_pkg::TX_DLY_BIT] = second & pc.tx_dly;
            end
            spcr_pkg::IDX_IR_CTRL:
            begin
                if (second)
                begin
                    d[spcr_pkg::IR_MODE_LSB +: 2] = irc.mode;
                    d[spcr_pkg::HALF_DUPLEX_BIT] = irc.half;
                    d[spcr_pkg::IR_TX_INV_BIT] = irc.tx_inv;
                    d[spcr_pkg::IR_RX_INV_BIT] = irc.rx_inv;
                end
            end
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb
    begin
        st_nxt = st_r;

        // Bus slave: one wait state, ack for one cycle, unmapped reads zero
        st_nxt.ack = cyc_i && stb_i && !st_r.ack;
        if (cyc_i && stb_i && !st_r.ack)
        begin
            st_nxt.rdata = read_reg(st_r.port[p2], st_r.ir, p2, idx);
        end
        if (wr_now)
        begin
            unique case (idx)
                spcr_pkg::IDX_ENABLE: st_nxt.port[p2].en = dat_i[spcr_pkg::ENABLE_BIT];
                spcr_pkg::IDX_BASE_HI: st_nxt.port[p2].base_hi = dat_i[7:0];
                spcr_pkg::IDX_BASE_LO: st_nxt.port[p2].base_lo = dat_i[7:0];
                spcr_pkg::IDX_IRQ_SEL: st_nxt.port[p2].irq = dat_i[3:0];
                spcr_pkg::IDX_LINE_DRV:
                begin
                    st_nxt.port[p2].rts_inv = dat_i[spcr_pkg::RTS_INV_BIT];
                    st_nxt.port[p2].diff_mode = dat_i[spcr_pkg::DIFF_MODE_BIT];
                    st_nxt.port[p2].rx_dly = p2 & dat_i[spcr_pkg::RX_DLY_BIT];
                    st_nxt.port[p2].tx_dly = p2 & dat_i[spcr_pkg::TX_DLY_BIT];
                end
                spcr_pkg::IDX_IR_CTRL:
                begin
                    if (p2)
                    begin
                        st_nxt.ir.mode = dat_i[spcr_pkg::IR_MODE_LSB +: 2];
                        st_nxt.ir.half = dat_i[spcr_pkg::HALF_DUPLEX_BIT];
                        st_nxt.ir.tx_inv = dat_i[spcr_pkg::IR_TX_INV_BIT];
                        st_nxt.ir.rx_inv = dat_i[spcr_pkg::IR_RX_INV_BIT];
                    end
                end
                default: st_nxt.ack = st_nxt.ack;
            endcase
        end

        // Line driver: in differential mode low while sending, flipped by the invert bit; otherwise follows the UART's RTS
        for (int p = 0; p < 2; p++)
        begin
            if (st_r.port[p].diff_mode)
            begin
                st_nxt.rts_n[p] = !tx_active_i[p] ^ st_r.port[p].rts_inv;
            end
            else
            begin
                st_nxt.rts_n[p] = uart_rts_n_i[p];
            end
        end

        // Receive pin: a change counts once the last two stages agree
        st_nxt.rx_sync = {st_r.rx_sync[1:0], ir_receive_input_i};
        if (st_r.rx_sync[2] == st_r.rx_sync[1])
        begin
            st_nxt.rx_level = st_r.rx_sync[2] ^ st_r.ir.rx_inv;
        end
        // A received pulse marks a zero bit
        st_nxt.rxd = !(ir_on && rx_open && st_r.rx_level);

        // Turnaround between directions
        unique case (st_r.dir)
            spcr_pkg::DIR_RX:
            begin
                if (tx_pending_i)
                begin
                    if (st_r.ir.half && st_r.port[1].tx_dly)
                    begin
                        st_nxt.dir = spcr_pkg::DIR_TX_WAIT;
                        st_nxt.dly_cnt = spcr_pkg::TURN_TICKS;
                    end
                    else
                    begin
                        st_nxt.dir = spcr_pkg::DIR_TX;
                    end
                end
            end
            spcr_pkg::DIR_TX_WAIT:
            begin
                if (!tx_pending_i)
                begin
                    st_nxt.dir = spcr_pkg::DIR_RX;
                end
                else if (!st_r.ir.half)
                begin
                    st_nxt.dir = spcr_pkg::DIR_TX;
                end
                else if (baud16_tick_i)
                begin
                    st_nxt.dly_cnt = st_r.dly_cnt - 10'h001;
                    if (st_r.dly_cnt == 10'h001)
                    begin
                        st_nxt.dir = spcr_pkg::DIR_TX;
                    end
                end
            end
            spcr_pkg::DIR_TX:
            begin
                if (!tx_pending_i)
                begin
                    if (st_r.ir.half && st_r.port[1].rx_dly)
                    begin
                        st_nxt.dir = spcr_pkg::DIR_RX_WAIT;
                        st_nxt.dly_cnt = spcr_pkg::TURN_TICKS;
                    end
                    else
                    begin
                        st_nxt.dir = spcr_pkg::DIR_RX;
                    end
                end
            end
            spcr_pkg::DIR_RX_WAIT:
            begin
                if (tx_pending_i)
                begin
                    st_nxt.dir = spcr_pkg::DIR_TX;
                end
                else if (!st_r.ir.half)
                begin
                    st_nxt.dir = spcr_pkg::DIR_RX;
                end
                else if (baud16_tick_i)
                begin
                    st_nxt.dly_cnt = st_r.dly_cnt - 10'h001;
                    if (st_r.dly_cnt == 10'h001)
                    begin
                        st_nxt.dir = spcr_pkg::DIR_RX;
                    end
                end
            end
        endcase

        // Transmit pulses: one at the start of every zero bit
        st_nxt.txd_d = txd_i;
        if (txd_i != st_r.txd_d)
        begin
            st_nxt.phase = 4'h0;
        end
        else if (baud16_tick_i)
        begin
            st_nxt.phase = st_r.phase + 4'h1;
        end
        if (st_r.pulse_cnt != 6'h00 && (!st_r.pulse_ticks || baud16_tick_i))
        begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 6'h01;
        end
        if (ir_on && !txd_i && ((st_r.txd_d && !txd_i) || (baud16_tick_i && st_r.phase == spcr_pkg::LAST_PHASE)))
        begin
            if (st_r.ir.mode == spcr_pkg::IR_MODE_RATIO)
            begin
                st_nxt.pulse_cnt = spcr_pkg::IR_PULSE_TICKS;
                st_nxt.pulse_ticks = 1'b1;
            end
            else
            begin
                st_nxt.pulse_cnt = spcr_pkg::IR_PULSE_CYC;
                st_nxt.pulse_ticks = 1'b0;
            end
        end
        st_nxt.ir_tx = (ir_on && st_nxt.pulse_cnt != 6'h00) ^ st_r.ir.tx_inv;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            st_r.port[0].en <= spcr_pkg::P1_ENABLE_RST;
            st_r.port[1].en <= spcr_pkg::P2_ENABLE_RST;
            st_r.port[0].base_hi <= spcr_pkg::P1_BASE_HI_RST;
            st_r.port[0].base_lo <= spcr_pkg::P1_BASE_LO_RST;
            st_r.port[1].base_hi <= spcr_pkg::P2_BASE_HI_RST;
            st_r.port[1].base_lo <= spcr_pkg::P2_BASE_LO_RST;
            st_r.port[0].irq <= spcr_pkg::P1_IRQ_RST;
            st_r.port[1].irq <= spcr_pkg::P2_IRQ_RST;
            st_r.ir.mode <= spcr_pkg::IR_MODE_RST;
            st_r.ir.half <= spcr_pkg::HALF_DUPLEX_RST;
            st_r.rts_n <= 2'h3;
            st_r.rx_sync <= 3'h0;
            st_r.rxd <= 1'b1;
            st_r.txd_d <= 1'b1;
            st_r.dir <= spcr_pkg::DIR_RX;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign ack_o = st_r.ack;
    assign dat_o = {24'h000000, st_r.rdata};
    assign rts_n_o = st_r.rts_n;
    assign rxd_o = st_r.rxd;
    assign ir_transmit_output_o = st_r.ir_tx;
    // Core must not start a character while held
    assign tx_hold_o = ir_on && st_r.ir.half && st_r.dir != spcr_pkg::DIR_TX;

    for (genvar p = 0; p < 2; p++)
    begin : g_port
        assign enable_o[p] = st_r.port[p].en;
        assign io_base_o[p] = {st_r.port[p].base_hi, st_r.port[p].base_lo};
        assign irq_channel_o[p] = st_r.port[p].irq;
    end

    property p_enable_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> enable_o == 2'h3;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("Enables not set after reset");

    property p_base_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> io_base_o[0] == 16'h03f8 && io_base_o[1] == 16'h02f8;
    endproperty
    a_base_reset: assert property (p_base_reset) else $error("Base addresses wrong after reset");

    property p_base_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_now && !p2 && idx == 8'h60) |=> io_base_o[0][15:8] == $past(dat_i[7:0]);
    endproperty
    a_base_write: assert property (p_base_write) else $error("Base high byte not written");

    property p_irq_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> irq_channel_o[0] == 4'h4 && irq_channel_o[1] == 4'h3;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("Interrupt channels wrong after reset");

    property p_irq_read;
        @(posedge clk_i) disable iff (rst_i)
        (ack_o && !we_i && idx == 8'h70) |-> dat_o[31:4] == 28'h0000000 && dat_o[3:0] == irq_channel_o[p2];
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("Interrupt channel read wrong");

    property p_enable_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr_now && p2 && idx == 8'h30 && !dat_i[0]) |=> !enable_o[1] ##1 !enable_o[1];
    endproperty
    a_enable_clear: assert property (p_enable_clear) else $error("Second port not disabled");

    property p_rts_diff;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.port[0].diff_mode && tx_active_i[0] && $stable(st_r.port[0])) |=> rts_n_o[0] == $past(st_r.port[0].rts_inv);
    endproperty
    a_rts_diff: assert property (p_rts_diff) else $error("RTS not driven while sending");

    property p_rts_plain;
        @(posedge clk_i) disable iff (rst_i)
        !st_r.port[1].diff_mode |=> rts_n_o[1] == $past(uart_rts_n_i[1]);
    endproperty
    a_rts_plain: assert property (p_rts_plain) else $error("RTS inverted outside differential mode");

    property p_tx_delay;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.dir == spcr_pkg::DIR_RX && tx_pending_i && ir_on && st_r.ir.half && st_r.port[1].tx_dly)
            |=> tx_hold_o [*2];
    endproperty
    a_tx_delay: assert property (p_tx_delay) else $error("Transmit not held for turnaround");

    property p_full_duplex;
        @(posedge clk_i) disable iff (rst_i)
        !st_r.ir.half |-> !tx_hold_o ##1 (st_r.dir == spcr_pkg::DIR_RX || st_r.dir == spcr_pkg::DIR_TX || st_r.ir.half);
    endproperty
    a_full_duplex: assert property (p_full_duplex) else $error("Turnaround active in full duplex");

    property p_ir_idle;
        @(posedge clk_i) disable iff (rst_i)
        (!ir_on && $stable(st_r.ir.tx_inv)) |=> ir_transmit_output_o == $past(st_r.ir.tx_inv);
    endproperty
    a_ir_idle: assert property (p_ir_idle) else $error("Infrared output not idle");

    property p_reserved_read;
        @(posedge clk_i) disable iff (rst_i)
        (ack_o && !we_i && idx == 8'hf1) |-> dat_o[31:5] == 27'h0000000;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("Reserved bits not zero");

endmodule // spcr_top

`default_nettype wire

/* File: bench/spcr_line_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Line side: baud tick source at a selectable rate and an infrared receiver front end
module spcr_line_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] tick_div_i,
    input wire logic ir_active_i,
    input wire logic ir_invert_i,
    output logic baud16_tick_o,
    output logic ir_pin_o
);
    logic [2:0] cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || cnt_r == tick_div_i)
        begin
            cnt_r <= 3'h0;
        end
        else
        begin
            cnt_r <= cnt_r + 3'h1;
        end
        baud16_tick_o <= !rst_i && cnt_r == tick_div_i;
        // Inverting transceivers present the active pulse as a low level
        ir_pin_o <= ir_active_i ^ ir_invert_i;
    end
endmodule // spcr_line_model

`default_nettype wire

/* File: bench/spcr_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module spcr_top_tb;
    localparam logic [7:0] IDX_TAB [7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0, 8'hf1, 8'h55};
    logic clk;
    logic rst;
    logic cyc;
    logic stb;
    logic we;
    logic [spcr_pkg::ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic [1:0] enable;
    logic [1:0][15:0] io_base;
    logic [1:0][3:0] irq_ch;
    logic [1:0] tx_active;
    logic [1:0] uart_rts_n;
    logic [1:0] rts_n;
    logic tick;
    logic txd;
    logic tx_pending;
    logic tx_hold;
    logic ir_pin;
    logic ir_tx;
    logic rxd;
    logic [2:0] tick_div;
    logic ir_active;
    logic ir_inv;
    int error_cnt;
    int compares;
    logic [7:0] shadow [2][256];

    spcr_top spcr_top_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .enable_o(enable), .io_base_o(io_base),
        .irq_channel_o(irq_ch), .tx_active_i(tx_active), .uart_rts_n_i(uart_rts_n), .rts_n_o(rts_n),
        .baud16_tick_i(tick), .txd_i(txd), .tx_pending_i(tx_pending), .tx_hold_o(tx_hold),
        .ir_receive_input_i(ir_pin), .ir_transmit_output_o(ir_tx), .rxd_o(rxd));

    spcr_line_model spcr_line_model_inst (.clk_i(clk), .rst_i(rst), .tick_div_i(tick_div),
        .ir_active_i(ir_active), .ir_invert_i(ir_inv), .baud16_tick_o(tick), .ir_pin_o(ir_pin));

    always #25 clk = ~clk;

    function automatic logic [7:0] rst_of(input logic p, input logic [7:0] ix);
        case (ix)
            8'h30: return 8'h01;
            8'h60: return p ? 8'h02 : 8'h03;
            8'h61: return 8'hf8;
            8'h70: return p ? 8'h03 : 8'h04;
            8'hf1: return p ? 8'h04 : 8'h00;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input logic p, input logic [7:0] ix);
        case (ix)
            8'h30: return 8'h01;
            8'h60, 8'h61: return 8'hff;
            8'h70: return 8'h0f;
            8'hf0: return p ? 8'h3c : 8'h30;
            8'hf1: return p ? 8'h1f : 8'h00;
            default: return 8'h00;
        endcase
    endfunction

    // Mode 11 width depends on where the pulse falls against the tick grid
    function automatic logic pulse_ok(input logic [1:0] mode, input int n);
        if (mode == 2'b10)
            return n == int'(spcr_pkg::IR_PULSE_CYC);
        if (mode == 2'b11)
            return n >= 8 && n <= 13;
        return n == 0;
    endfunction

    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic wr, input logic p, input logic [7:0] ix, input logic [7:0] wd,
                      input logic s0, output logic [31:0] rd);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {p, ix, 2'b00};
        sel <= {3'b000, s0};
        wdat <= {24'($urandom), wd};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20)
        begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    initial
    begin
        logic [31:0] rd;
        logic [7:0] ix;
        logic [7:0] d;
        int n;
        clk = 1'b0;
        rst = 1'b1;
        {cyc, stb, we} = 3'b000;
        adr = '0;
        sel = 4'h0;
        wdat = 32'h0;
        tx_active = 2'b00;
        uart_rts_n = 2'b11;
        {txd, tx_pending} = 2'b10;
        tick_div = 3'h3;
        {ir_active, ir_inv} = 2'b00;
        error_cnt = 0;
        compares = 0;
        void'($urandom(32'h3d01262d));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check(64'({enable, io_base, irq_ch}), 64'({2'b11, 16'h02f8, 16'h03f8, 4'h3, 4'h4}));
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 7; i++)
            begin
                ix = IDX_TAB[i];
                wb(1'b0, 1'(p), ix, 8'h00, 1'b0, rd);
                check(64'(rd), 64'(rst_of(1'(p), ix)));
                shadow[p][ix] = rst_of(1'(p), ix);
            end
        end
        // Clearing the second port's enable must show on its output
        wb(1'b1, 1'b1, 8'h30, 8'h00, 1'b1, rd);
        @(posedge clk);
        check(64'(enable), 64'h1);
        repeat (3)
        begin
            for (int p = 0; p < 2; p++)
            begin
                for (int i = 0; i < 7; i++)
                begin
                    ix = IDX_TAB[i];
                    d = 8'($urandom);
                    wb(1'b1, 1'(p), ix, d, 1'b1, rd);
                    shadow[p][ix] = d & mask_of(1'(p), ix);
                    wb(1'b0, 1'(p), ix, 8'h00, 1'b0, rd);
                    check(64'(rd), 64'(shadow[p][ix]));
                end
            end
            // Write without the low byte lane enabled must leave the register alone
            wb(1'b1, 1'b0, 8'h61, ~shadow[0][8'h61], 1'b0, rd);
            // Let the write edge settle so a wrongly taken write would show
            @(posedge clk);
            check(64'({enable, io_base, irq_ch}), 64'({shadow[1][8'h30][0], shadow[0][8'h30][0],
                shadow[1][8'h60], shadow[1][8'h61], shadow[0][8'h60], shadow[0][8'h61],
                shadow[1][8'h70][3:0], shadow[0][8'h70][3:0]}));
        end
        for (int k = 0; k < 32; k++)
        begin
            wb(1'b1, k[4], 8'hf0, {2'b00, k[1], k[0], 4'h0}, 1'b1, rd);
            tx_active[k[4]] <= k[2];
            uart_rts_n[k[4]] <= k[3];
            repeat (2) @(posedge clk);
            check(64'(rts_n[k[4]]), 64'(k[0] ? (!k[2] ^ k[1]) : k[3]));
        end
        tx_active <= 2'b00;
        for (int k = 0; k < 8; k++)
        begin
            wb(1'b1, 1'b1, 8'hf1, {3'b000, k[2:1], 1'b1, k[0], 1'b0}, 1'b1, rd);
            repeat (2) @(posedge clk);
            check(64'(ir_tx), 64'(k[0]));
            txd <= 1'b0;
            n = 0;
            repeat (50)
            begin
                @(posedge clk);
                n += int'(ir_tx !== k[0]);
            end
            txd <= 1'b1;
            repeat (70) @(posedge clk);
            check(64'(pulse_ok(k[2:1], n)), 64'h1);
        end
        for (int k = 0; k < 8; k++)
        begin
            wb(1'b1, 1'b1, 8'hf1, {3'b000, k[2], 1'b0, 1'b1, 1'b0, k[1]}, 1'b1, rd);
            ir_inv <= k[1];
            ir_active <= k[0];
            repeat (10) @(posedge clk);
            check(64'(rxd), 64'(!(k[2] && k[0])));
        end
        ir_active <= 1'b0;
        ir_inv <= 1'b0;
        wb(1'b1, 1'b1, 8'hf0, 8'h0c, 1'b1, rd);
        wb(1'b1, 1'b1, 8'hf1, 8'h14, 1'b1, rd);
        tx_pending <= 1'b1;
        repeat (5) @(posedge clk);
        check(64'(tx_hold), 64'h1);
        n = 0;
        while (tx_hold === 1'b1 && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        check(64'(n > 2530 && n < 2570), 64'h1);
        tx_pending <= 1'b0;
        ir_active <= 1'b1;
        repeat (20) @(posedge clk);
        check(64'(rxd), 64'h1);
        repeat (2600) @(posedge clk);
        check(64'(rxd), 64'h0);
        ir_active <= 1'b0;
        tick_div <= 3'h1;
        wb(1'b1, 1'b1, 8'hf1, 8'h10, 1'b1, rd);
        tx_pending <= 1'b1;
        repeat (5) @(posedge clk);
        check(64'(tx_hold), 64'h0);
        tx_pending <= 1'b0;
        ir_active <= 1'b1;
        repeat (20) @(posedge clk);
        check(64'(rxd), 64'h0);
        report_and_stop();
    end
endmodule // spcr_top_tb

`default_nettype wire
